// ---- rtl/rtcs_top.v ----
// rtc prescaler, wakeup timer, alarms, key port and shift unit
`timescale 1ns/10ps
`include "rtcs_defs.vh"
module rtcs_top (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// kernel clock pin, sampled
	input  wire        rtc_kernel_clock,
	// calendar now, in alarm layout, and weekday
	input  wire [29:0] cal_time_date,
	input  wire [3:0]  cal_weekday,
	// events toward calendar and system
	output reg         one_second_tick,
	output reg         add_second_pulse,
	output reg         wakeup_flag,
	output reg         alarm_first_flag,
	output reg         alarm_second_flag
);

	// kernel clock synchroniser and filter
	reg        ks1_reg, ks2_reg, ks3_reg, kflt_reg;
	wire       kedge;
	// registers
	reg [31:0] ctrl_reg;
	reg [31:0] pre_reg;
	reg [15:0] wkr_reg;
	reg [31:0] alm1_reg, alm2_reg;
	reg        unlocked_reg, key_half_reg, synced_reg;
	reg        shift_pend_reg, sh_add_reg;
	reg [14:0] sh_subtract_fraction_reg;
	// counters
	reg [6:0]  acnt_reg;
	reg [15:0] scnt_reg;
	reg [15:0] scnt_next;
	reg [3:0]  wdiv_reg;
	reg [16:0] wcnt_reg;
	reg [16:0] wact_reg;
	reg        wakeup_timer_enable_d_reg, m1_d_reg, m2_d_reg;
	// decode
	wire       acc, wr, rd_phase, prot_ok, st_wr, mapped;
	wire       apre, wclk_ev, m1, m2;
	wire [2:0] wsel;
	reg [31:0] rdata;

	// alarm match with per-field masks
	function alarm_match;
		input [31:0] a;
		input [29:0] c;
		input [3:0]  wd;
		reg          dok;
		reg          hok;
		reg          mok;
		reg          sok;
		begin
			if (a[`RTCS_ALM_WDAY_SEL])
				dok = (a[27:24] == wd);
			else
				dok = (a[29:24] == c[29:24]);
			hok = (a[22:16] == c[22:16]);
			mok = (a[14:8] == c[14:8]);
			sok = (a[6:0] == c[6:0]);
			alarm_match = (dok | a[`RTCS_ALM_DATE_MASK])
				& (hok | a[`RTCS_ALM_HOUR_MASK])
				& (mok | a[`RTCS_ALM_MIN_MASK])
				& (sok | a[`RTCS_ALM_SEC_MASK]);
		end
	endfunction

	// three-stage sampling of the kernel clock pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ks1_reg  <= 1'b0;
			ks2_reg  <= 1'b0;
			ks3_reg  <= 1'b0;
			kflt_reg <= 1'b0;
		end else begin
			ks1_reg <= rtc_kernel_clock;
			ks2_reg <= ks1_reg;
			ks3_reg <= ks2_reg;
			if (ks2_reg == ks3_reg)
				kflt_reg <= ks3_reg;
		end
	end
	assign kedge = ks2_reg & ks3_reg & ~kflt_reg;

	// apb decode, one wait state per access
	assign acc      = psel & penable & pready;
	assign wr       = acc & pwrite;
	assign rd_phase = psel & penable & ~pready;
	assign st_wr    = wr & (paddr == `RTCS_STAT_OFS); // no unlock needed
	assign prot_ok  = wr & unlocked_reg;
	assign mapped   = (paddr[1:0] == 2'b00) &&
		((paddr == `RTCS_CTRL_OFS) || (paddr == `RTCS_STAT_OFS) ||
		 (paddr == `RTCS_PRE_OFS)  || (paddr == `RTCS_WKR_OFS)  ||
		 (paddr == `RTCS_ALM1_OFS) || (paddr == `RTCS_ALM2_OFS) ||
		 (paddr == `RTCS_KEY_OFS)  || (paddr == `RTCS_SUBS_OFS) ||
		 (paddr == `RTCS_SHIFT_OFS));

	// read mux
	always @* begin
		rdata = 32'h00000000;
		case (paddr)
		`RTCS_CTRL_OFS: rdata = ctrl_reg;
		`RTCS_STAT_OFS: begin
			rdata[`RTCS_ST_WT_FLAG]    = wakeup_flag;
			rdata[`RTCS_ST_ALM2_FLAG]  = alarm_second_flag;
			rdata[`RTCS_ST_ALM1_FLAG]  = alarm_first_flag;
			rdata[`RTCS_ST_SYNCED]     = synced_reg;
			rdata[`RTCS_ST_SHIFT_PEND] = shift_pend_reg;
		end
		`RTCS_PRE_OFS:  rdata = pre_reg;
		`RTCS_WKR_OFS:  rdata = {16'h0000, wkr_reg};
		`RTCS_ALM1_OFS: rdata = alm1_reg;
		`RTCS_ALM2_OFS: rdata = alm2_reg;
		`RTCS_SUBS_OFS: rdata = {16'h0000, scnt_reg};
		default:        rdata = 32'h00000000;
		endcase
	end

	// apb answer registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= rd_phase;
			pslverr <= rd_phase & ~mapped;
			if (rd_phase)
				prdata <= rdata;
		end
	end

	// software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `RTCS_CTRL_RST;
			pre_reg  <= `RTCS_PRE_RST;
			wkr_reg  <= `RTCS_WKR_RST;
			alm1_reg <= `RTCS_ALM_RST;
			alm2_reg <= `RTCS_ALM_RST;
		end else if (prot_ok) begin
			case (paddr)
			`RTCS_CTRL_OFS: ctrl_reg <= {21'h000000, pwdata[10:8],
				5'h00, pwdata[2:0]};
			`RTCS_PRE_OFS:  pre_reg  <= {9'h000, pwdata[22:16],
				1'b0, pwdata[14:0]};
			`RTCS_WKR_OFS:  wkr_reg  <= pwdata[15:0];
			`RTCS_ALM1_OFS: alm1_reg <= pwdata;
			`RTCS_ALM2_OFS: alm2_reg <= pwdata;
			default:        ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlocked_reg <= 1'b0;
			key_half_reg <= 1'b0;
		end else if (wr && paddr == `RTCS_KEY_OFS) begin
			if (pwdata[7:0] == `RTCS_KEY_FIRST) begin
				key_half_reg <= 1'b1;
				unlocked_reg <= 1'b0;
			end else if (key_half_reg &&
				pwdata[7:0] == `RTCS_KEY_SECOND) begin
				key_half_reg <= 1'b0;
				unlocked_reg <= 1'b1;
			end else begin
				key_half_reg <= 1'b0;
				unlocked_reg <= 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acnt_reg <= 7'h00;
		else if (kedge) begin
			if (acnt_reg == 7'h00)
				acnt_reg <= pre_reg[`RTCS_PRE_ADIV_HI:`RTCS_PRE_ADIV_LO];
			else
				acnt_reg <= acnt_reg - 7'h01;
		end
	end
	assign apre = kedge & (acnt_reg == 7'h00);

	// sync counter next value, shift add
	always @* begin
		scnt_next = scnt_reg;
		if (shift_pend_reg && kedge)
			scnt_next = scnt_reg + {1'b0, sh_subtract_fraction_reg};
		else if (apre) begin
			if (scnt_reg == 16'h0000)
				scnt_next = {1'b0,
					pre_reg[`RTCS_PRE_SDIV_HI:`RTCS_PRE_SDIV_LO]};
			else
				scnt_next = scnt_reg - 16'h0001;
		end
	end

	// sync prescaler and one second tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scnt_reg        <= 16'h00ff;
			one_second_tick <= 1'b0;
		end else begin
			scnt_reg <= scnt_next;
			one_second_tick <= apre & ~(shift_pend_reg & kedge)
				& (scnt_reg == 16'h0000);
		end
	end

	// shift unit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_pend_reg   <= 1'b0;
			sh_add_reg       <= 1'b0;
			sh_subtract_fraction_reg      <= 15'h0000;
			add_second_pulse <= 1'b0;
			synced_reg       <= 1'b0;
		end else begin
			add_second_pulse <= 1'b0;
			if (shift_pend_reg && kedge) begin
				shift_pend_reg <= 1'b0;
				add_second_pulse <= sh_add_reg;
				synced_reg <= 1'b1;
			end else if (prot_ok && paddr == `RTCS_SHIFT_OFS &&
				!shift_pend_reg) begin
				// only when idle; set on write
				shift_pend_reg <= 1'b1;
				sh_add_reg     <= pwdata[`RTCS_SH_ADD1S];
				sh_subtract_fraction_reg    <= pwdata[`RTCS_SH_SUBTRACT_FRACTION_HI:0];
				synced_reg     <= 1'b0;
			end else if (one_second_tick && !shift_pend_reg)
				synced_reg <= 1'b1;
			else if (st_wr && !pwdata[`RTCS_ST_SYNCED])
				synced_reg <= 1'b0;
		end
	end

	assign wsel    = ctrl_reg[`RTCS_CTRL_WSEL_HI:`RTCS_CTRL_WSEL_LO];
	assign wclk_ev = wsel[2] ? one_second_tick :
		(kedge && (wdiv_reg | ~(4'hf >> wsel[1:0])) == 4'hf);

	// kernel divider for wakeup clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wdiv_reg <= 4'h0;
		else if (kedge)
			wdiv_reg <= wdiv_reg + 4'h1;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt_reg   <= 17'h00000;
			wact_reg   <= 17'h00000;
			wakeup_timer_enable_d_reg <= 1'b0;
		end else begin
			wakeup_timer_enable_d_reg <= ctrl_reg[`RTCS_CTRL_WT_EN];
			if (ctrl_reg[`RTCS_CTRL_WT_EN] && !wakeup_timer_enable_d_reg) begin
				wcnt_reg <= {wsel[2] & wsel[1], wkr_reg};
				wact_reg <= {wsel[2] & wsel[1], wkr_reg};
			end else if (wakeup_timer_enable_d_reg && wclk_ev) begin
				if (wcnt_reg == 17'h00000) begin
					// next period; select 010 one later
					wcnt_reg <= (wsel == 3'b010) ?
						wact_reg : {wsel[2] & wsel[1], wkr_reg};
					wact_reg <= {wsel[2] & wsel[1], wkr_reg};
				end else
					wcnt_reg <= wcnt_reg - 17'h00001;
			end
		end
	end

	assign m1 = ctrl_reg[`RTCS_CTRL_ALM1_EN] &
		alarm_match(alm1_reg, cal_time_date, cal_weekday);
	assign m2 = ctrl_reg[`RTCS_CTRL_ALM2_EN] &
		alarm_match(alm2_reg, cal_time_date, cal_weekday);

	// event flags: set wins over a write of zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m1_d_reg          <= 1'b0;
			m2_d_reg          <= 1'b0;
			wakeup_flag       <= 1'b0;
			alarm_first_flag  <= 1'b0;
			alarm_second_flag <= 1'b0;
		end else begin
			m1_d_reg <= m1;
			m2_d_reg <= m2;
			if (wakeup_timer_enable_d_reg && wclk_ev && wcnt_reg == 17'h00000)
				wakeup_flag <= 1'b1;
			else if (st_wr && !pwdata[`RTCS_ST_WT_FLAG])
				wakeup_flag <= 1'b0;
			if (m1 && !m1_d_reg)
				alarm_first_flag <= 1'b1;
			else if (st_wr && !pwdata[`RTCS_ST_ALM1_FLAG])
				alarm_first_flag <= 1'b0;
			if (m2 && !m2_d_reg)
				alarm_second_flag <= 1'b1;
			else if (st_wr && !pwdata[`RTCS_ST_ALM2_FLAG])
				alarm_second_flag <= 1'b0;
		end
	end

endmodule // rtcs_top

// ---- rtl/rtcs_defs.vh ----
// register map, field positions, reset values and keys of the rtc slice
`ifndef RTCS_DEFS_VH
`define RTCS_DEFS_VH
// register byte offsets
`define RTCS_CTRL_OFS      8'h08
`define RTCS_STAT_OFS      8'h0c
`define RTCS_PRE_OFS       8'h10
`define RTCS_WKR_OFS       8'h14
`define RTCS_ALM1_OFS      8'h1c
`define RTCS_ALM2_OFS      8'h20
`define RTCS_KEY_OFS       8'h24
`define RTCS_SUBS_OFS      8'h28
`define RTCS_SHIFT_OFS     8'h2c
// reset values
`define RTCS_PRE_RST       32'h007f00ff
`define RTCS_WKR_RST       16'hffff
`define RTCS_ALM_RST       32'h00000000
`define RTCS_CTRL_RST      32'h00000000
// control fields
`define RTCS_CTRL_WSEL_HI  2
`define RTCS_CTRL_WSEL_LO  0
`define RTCS_CTRL_ALM1_EN  8
`define RTCS_CTRL_ALM2_EN  9
`define RTCS_CTRL_WT_EN    10
// status fields
`define RTCS_ST_WT_FLAG    10
`define RTCS_ST_ALM2_FLAG  9
`define RTCS_ST_ALM1_FLAG  8
`define RTCS_ST_SYNCED     5
`define RTCS_ST_SHIFT_PEND 3
// prescaler fields
`define RTCS_PRE_ADIV_HI   22
`define RTCS_PRE_ADIV_LO   16
`define RTCS_PRE_SDIV_HI   14
`define RTCS_PRE_SDIV_LO   0
// alarm fields
`define RTCS_ALM_DATE_MASK 31
`define RTCS_ALM_WDAY_SEL  30
`define RTCS_ALM_HOUR_MASK 23
`define RTCS_ALM_MIN_MASK  15
`define RTCS_ALM_SEC_MASK  7
// shift fields
`define RTCS_SH_ADD1S      31
`define RTCS_SH_SUBTRACT_FRACTION_HI    14
// unlock key sequence
`define RTCS_KEY_FIRST     8'hca
`define RTCS_KEY_SECOND    8'h53
`endif

// ---- verif/rtcs_top_properties.sv ----
// concurrent checks on the rtc slice bus and event ports
`timescale 1ns/10ps
module rtcs_props (
	// apb slave
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// kernel clock and calendar
	input wire        rtc_kernel_clock,
	input wire [29:0] cal_time_date,
	input wire [3:0]  cal_weekday,
	// events
	input wire        one_second_tick,
	input wire        add_second_pulse,
	input wire        wakeup_flag,
	input wire        alarm_first_flag,
	input wire        alarm_second_flag
);
	// completed reads and status writes
	wire rd_done = psel && penable && pready && !pwrite;
	wire st_wr   = psel && penable && pready && pwrite && paddr == 8'h0c;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	chk_unmapped_err: assert property (
		psel && penable && pready && paddr == 8'h04 |-> pslverr)
		else $error("no error on unmapped access");
	chk_key_zero: assert property (
		rd_done && paddr == 8'h24 |-> prdata == 32'h0)
		else $error("key port read not zero");
	chk_shift_zero: assert property (
		rd_done && paddr == 8'h2c |-> prdata == 32'h0)
		else $error("shift read not zero");
	chk_subs_upper: assert property (
		rd_done && paddr == 8'h28 |-> prdata[31:16] == 16'h0)
		else $error("subsecond upper half set");
	chk_tick_pulse: assert property (one_second_tick |=> !one_second_tick)
		else $error("tick longer than a cycle");
	chk_add_pulse: assert property (add_second_pulse |=> !add_second_pulse)
		else $error("add pulse too long");
	chk_wake_hold: assert property (wakeup_flag && !st_wr |=> wakeup_flag)
		else $error("wakeup flag dropped");
	chk_alarm_hold: assert property (
		alarm_first_flag && !st_wr |=> alarm_first_flag)
		else $error("alarm flag dropped");
	// main scenarios reached
	cov_tick: cover property (one_second_tick);
	cov_wake: cover property ($rose(wakeup_flag));
	cov_err: cover property (pready && pslverr);
endmodule // rtcs_props

// ---- verif/rtcs_top_tb.sv ----
// self-checking bench for the rtc slice
`timescale 1ns/10ps
`include "rtcs_defs.vh"
module rtcs_top_tb;
	// stimulus and results
	reg         pclk, presetn, psel, penable, pwrite, kclk, kstop, er;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, rd;
	reg  [29:0] cal;
	reg  [3:0]  wday;
	reg  [34:0] rows [0:5];
	reg  [2:0]  sel;
	reg  [15:0] rl, ex;
	wire [31:0] prdata;
	wire        pready, pslverr, tick, addp, wflag, af1, af2;
	integer     bad_count, samples_checked, cyc, t1, n, i, kc, adds, dt;

	rtcs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rtc_kernel_clock(kclk), .cal_time_date(cal), .cal_weekday(wday),
		.one_second_tick(tick), .add_second_pulse(addp),
		.wakeup_flag(wflag), .alarm_first_flag(af1),
		.alarm_second_flag(af2));

	// bus clock, 4 ns
	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	// kernel clock at pclk/6, stoppable; cycle and add pulse counts
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (addp === 1'b1)
			adds <= adds + 1;
		if (!kstop) begin
			kc <= (kc == 2) ? 0 : kc + 1;
			if (kc == 2)
				kclk <= ~kclk;
		end
	end

	task close_out;
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task fail;
		bad_count = bad_count + 1;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		close_out;
	endtask
	// one apb transfer, held until pready is sampled high
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			fail;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	// bounded wait for the wakeup flag (k=0) or the tick (k=1)
	task waitsig(input integer k);
		n = 0;
		while ((k ? tick : wflag) !== 1'b1 && n < 8000) begin
			@(posedge pclk);
			n = n + 1;
		end
		if (n >= 8000)
			fail;
	endtask
	// cycles from the flag now set to the next one; nonzero nrl reloads
	task gap(input [15:0] nrl, output integer len);
		t1 = cyc;
		wr(`RTCS_STAT_OFS, 32'h0);
		if (nrl != 16'h0)
			wr(`RTCS_WKR_OFS, {16'h0, nrl});
		@(posedge pclk);
		waitsig(0);
		len = cyc - t1;
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		kclk = 0;
		kstop = 0;
		kc = 0;
		cyc = 0;
		adds = 0;
		cal = 0;
		wday = 0;
		bad_count = 0;
		samples_checked = 0;
		// reload never zero
		// select, reload, pclk cycles between wakeups
		rows[0] = {3'd0, 16'd1, 16'd192};
		rows[1] = {3'd1, 16'd2, 16'd144};
		rows[2] = {3'd2, 16'd3, 16'd96};
		rows[3] = {3'd3, 16'd4, 16'd60};
		rows[4] = {3'd4, 16'd1, 16'd96};
		rows[5] = {3'd5, 16'd2, 16'd144};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`RTCS_PRE_OFS, 32'hffffffff, 32'h007f00ff);
		rdc(`RTCS_WKR_OFS, 32'hffffffff, 32'h0000ffff);
		rdc(`RTCS_ALM1_OFS, 32'hffffffff, 32'h0);
		rdc(`RTCS_ALM2_OFS, 32'hffffffff, 32'h0);
		rdc(`RTCS_SHIFT_OFS, 32'hffffffff, 32'h0);
		rdc(8'h04, 32'hffffffff, 32'h0);
		chk(er, 1);
		wr(`RTCS_PRE_OFS, 32'h00010003);
		rdc(`RTCS_PRE_OFS, 32'hffffffff, 32'h007f00ff);
		wr(`RTCS_KEY_OFS, 32'hca);
		wr(`RTCS_KEY_OFS, 32'h53);
		rdc(`RTCS_KEY_OFS, 32'hffffffff, 32'h0);
		wr(`RTCS_PRE_OFS, 32'h00010003);
		rdc(`RTCS_PRE_OFS, 32'hffffffff, 32'h00010003);
		// tick every 2*4 kernel edges
		waitsig(1);
		t1 = cyc;
		@(posedge pclk);
		waitsig(1);
		chk(cyc - t1, 48);
		for (i = 0; i < 6; i = i + 1) begin
			{sel, rl, ex} = rows[i];
			wr(`RTCS_CTRL_OFS, 32'h0);
			wr(`RTCS_STAT_OFS, 32'h0);
			wr(`RTCS_WKR_OFS, {16'h0, rl});
			wr(`RTCS_CTRL_OFS, {21'h0, 1'b1, 7'h0, sel});
			waitsig(0);
			gap(16'h0, dt);
			chk(dt, {16'h0, ex});
		end
		// tick plus 65536: no wakeup within four ticks
		wr(`RTCS_CTRL_OFS, 32'h0);
		wr(`RTCS_STAT_OFS, 32'h0);
		wr(`RTCS_WKR_OFS, 32'h1);
		wr(`RTCS_CTRL_OFS, 32'h406);
		repeat (200) @(posedge pclk);
		chk(wflag, 0);
		// select 011: new reload serves the period after next wakeup
		wr(`RTCS_CTRL_OFS, 32'h0);
		wr(`RTCS_STAT_OFS, 32'h0);
		wr(`RTCS_WKR_OFS, 32'h4);
		wr(`RTCS_CTRL_OFS, 32'h403);
		waitsig(0);
		gap(16'h1, dt);
		chk(dt, 60);
		gap(16'h0, dt);
		chk(dt, 24);
		// select 010: one more period at the old reload
		wr(`RTCS_CTRL_OFS, 32'h0);
		wr(`RTCS_STAT_OFS, 32'h0);
		wr(`RTCS_WKR_OFS, 32'h4);
		wr(`RTCS_CTRL_OFS, 32'h402);
		waitsig(0);
		gap(16'h1, dt);
		chk(dt, 120);
		gap(16'h0, dt);
		chk(dt, 120);
		gap(16'h0, dt);
		chk(dt, 48);
		// alarm one: date masked; alarm two: weekday 3 only
		wr(`RTCS_CTRL_OFS, 32'h0);
		wr(`RTCS_STAT_OFS, 32'h0);
		wr(`RTCS_ALM1_OFS, 32'h80123456);
		rdc(`RTCS_ALM1_OFS, 32'hffffffff, 32'h80123456);
		wr(`RTCS_ALM2_OFS, 32'h43808080);
		cal <= 30'h15523456;
		wday <= 4'h3;
		wr(`RTCS_CTRL_OFS, 32'h300);
		repeat (8) @(posedge pclk);
		chk(af1, 0);
		chk(af2, 1);
		cal <= 30'h15123456;
		repeat (8) @(posedge pclk);
		chk(af1, 1);
		wr(`RTCS_STAT_OFS, 32'h0);
		@(posedge pclk);
		chk({af1, af2}, 0);
		// shadow synced by a tick, then shift held pending, kernel stopped
		waitsig(1);
		kstop <= 1'b1;
		repeat (8) @(posedge pclk);
		wr(`RTCS_SHIFT_OFS, 32'h80000002);
		rdc(`RTCS_STAT_OFS, 32'h28, 32'h08);
		wr(`RTCS_SHIFT_OFS, 32'h00000000);
		wr(`RTCS_STAT_OFS, 32'h0);
		rdc(`RTCS_STAT_OFS, 32'h28, 32'h08);
		kstop <= 1'b0;
		repeat (40) @(posedge pclk);
		chk(adds, 1);
		rdc(`RTCS_STAT_OFS, 32'h28, 32'h20);
		rdc(`RTCS_SHIFT_OFS, 32'hffffffff, 32'h0);
		rdc(`RTCS_SUBS_OFS, 32'hffff0000, 32'h0);
		// a wrong key locks again
		wr(`RTCS_KEY_OFS, 32'h0);
		wr(`RTCS_ALM2_OFS, 32'h0);
		rdc(`RTCS_ALM2_OFS, 32'hffffffff, 32'h43808080);
		// mid-run reset restores defaults and the lock
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rdc(`RTCS_PRE_OFS, 32'hffffffff, 32'h007f00ff);
		rdc(`RTCS_WKR_OFS, 32'hffffffff, 32'h0000ffff);
		wr(`RTCS_ALM1_OFS, 32'h1);
		rdc(`RTCS_ALM1_OFS, 32'hffffffff, 32'h0);
		close_out;
	end
endmodule // rtcs_top_tb

bind rtcs_top rtcs_props i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rtc_kernel_clock(rtc_kernel_clock), .cal_time_date(cal_time_date),
	.cal_weekday(cal_weekday), .one_second_tick(one_second_tick),
	.add_second_pulse(add_second_pulse), .wakeup_flag(wakeup_flag),
	.alarm_first_flag(alarm_first_flag),
	.alarm_second_flag(alarm_second_flag));
